// >>> tcr_readout.sv
// Purpose: Conversion control, reading buffer and link register access
// Assumes: temp_reading comes from the converter on ref_clk, already
//          scaled; scl_clk is the link master's clock
// Notes:   Link framing is recovered on ref_clk; only the bit shifter
//          runs on scl_clk
// Summary of operation
// - After reset the block idles in standby with no conversion.
// - A result is ready within fifty milliseconds of the request.
// - Conversion takes fifteen milliseconds, stores reading, returns standby.
// - Start bit clears itself by hardware once conversion completes.
// - Readings are sixteen bit two's complement, sign in top bit.
// - Buffer holds thirty-two readings, read back over the link.
// - Buffer word is sent high byte first, then low byte.
// - Setup, interrupt enable and pin setup registers reload defaults at every reset.
// - Aux pin levels at each start give two low address bits in modes 00 and 10, 0 in modes 01 and 11.
// - Aux pin one may act as an external conversion trigger.
// - Aux pin zero may act as an interrupt output.
// - In mode 11, pin one driven low begins a conversion.
// - Both pin mode fields reset to 10, pulled-down inputs.
// - Address byte bit zero selects write when zero, read when one.
module tcr_readout
  import tcr_pkg::*;
#(
  parameter int CONV_CYCLES = TCR_CONV_CYCLES,
  parameter int FIFO_DEPTH  = TCR_FIFO_DEPTH
) (
  input  wire logic                      ref_clk,
  input  wire logic                      reset_n,
  input  wire logic                      scl_clk,
  input  wire logic                      sda_i,
  output logic                           sda_o,
  output logic                           sda_oe,
  input  wire logic                      aux_pin_zero_i,
  output logic                           aux_pin_zero_o,
  output logic                           aux_pin_zero_oe,
  input  wire logic                      aux_pin_one_i,
  output logic                           aux_pin_one_o,
  output logic                           aux_pin_one_oe,
  input  wire logic [TCR_READ_WIDTH-1:0] temp_reading,
  output logic                           conversion_busy
);

  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);

  typedef struct packed {
    logic                      scl_m;
    logic                      scl_s;
    logic                      scl_p;
    logic                      sda_m;
    logic                      sda_s;
    logic                      sda_p;
    logic                      p0_m;
    logic                      p0_s;
    logic                      p1_m;
    logic                      p1_s;
    logic                      p1_p;
    tcr_link_state_type        i2_state;
    logic [3:0]                bit_cnt;
    logic                      rw;
    logic                      mack;
    logic                      sda_low;
    logic [7:0]                ptr;
    logic [7:0]                tx;
    logic                      byte_sel;
    logic [1:0]                addr_lo;
    logic [7:0]                setup;
    logic [7:0]                int_en;
    logic [7:0]                pin_setup;
    tcr_conv_state_type        cv_state;
    logic [CW-1:0]             cv_cnt;
    logic [TCR_READ_WIDTH-1:0] sample;
    logic                      pin0_drive;
    logic                      pin1_drive;
  } tcr_readout_state_type;

  tcr_readout_state_type     q;
  tcr_readout_state_type     d;
  logic [7:0]                link_shift_q;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_seen;
  logic                      stop_seen;
  logic [1:0]                mode_zero;
  logic [1:0]                mode_one;
  logic                      ext_trig;
  logic                      push_valid;
  logic                      push_ready;
  logic                      pop;
  logic                      word_valid;
  logic [TCR_READ_WIDTH-1:0] word_data;
  logic [7:0]                status;

  // Link side: only the bit shifter lives on the master's clock
  always_ff @(posedge scl_clk) begin
    link_shift_q <= {link_shift_q[6:0], sda_i};
  end

  // Shifter is read only while the synchronised clock is low,
  // so the byte is quiet for a whole low phase when sampled
  assign scl_rise   = q.scl_s & ~q.scl_p;
  assign scl_fall   = ~q.scl_s & q.scl_p;
  assign start_seen = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign stop_seen  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;

  assign mode_zero  = q.pin_setup[TCR_PIN_ZERO_LSB +: 2];
  assign mode_one   = q.pin_setup[TCR_PIN_ONE_LSB +: 2];
  assign ext_trig   = (mode_one == TCR_MODE_SPECIAL) & q.p1_p & ~q.p1_s;
  assign push_valid = (q.cv_state == TCR_CV_STORE);

  always_comb begin
    status = 8'h00;
    status[TCR_STAT_NONEMPTY] = word_valid;
    status[TCR_STAT_BUSY]     = (q.cv_state != TCR_CV_STANDBY);
  end

  function automatic logic [7:0] reg_read(
    input logic [7:0]                ptr,
    input logic                      low_half,
    input logic                      valid,
    input logic [TCR_READ_WIDTH-1:0] word,
    input logic [7:0]                stat,
    input logic [7:0]                int_en,
    input logic [7:0]                setup,
    input logic [7:0]                pins
  );
    logic [7:0] r;
    r = 8'h00;
    unique case (ptr)
      TCR_REG_STATUS:    r = stat;
      TCR_REG_INT_EN:    r = int_en;
      TCR_REG_SETUP:     r = setup;
      TCR_REG_PIN_SETUP: r = pins;
      TCR_REG_FIFO_WORD: r = !valid ? 8'h00 :
                             (low_half ? word[7:0] : word[15:8]);
      default:           r = 8'h00;
    endcase
    return r;
  endfunction

  always_comb begin
    d   = q;
    pop = 1'b0;

    // Pins from outside pass two flops before use
    d.scl_m = scl_clk;
    d.scl_s = q.scl_m;
    d.scl_p = q.scl_s;
    d.sda_m = sda_i;
    d.sda_s = q.sda_m;
    d.sda_p = q.sda_s;
    d.p0_m  = aux_pin_zero_i;
    d.p0_s  = q.p0_m;
    d.p1_m  = aux_pin_one_i;
    d.p1_s  = q.p1_m;
    d.p1_p  = q.p1_s;

    if (start_seen) begin
      d.i2_state = TCR_I2_ADDR;
      d.bit_cnt  = 4'h0;
      d.sda_low  = 1'b0;
      d.addr_lo  = {q.p1_s & ~mode_one[0], q.p0_s & ~mode_zero[0]};
    end else if (stop_seen) begin
      d.i2_state = TCR_I2_IDLE;
      d.sda_low  = 1'b0;
    end else if (q.i2_state != TCR_I2_IDLE) begin
      if (scl_rise) begin
        d.bit_cnt = q.bit_cnt + 4'h1;
        if (q.bit_cnt == TCR_BIT_ACK) begin
          d.mack = ~q.sda_s;
        end
      end
      if (scl_fall) begin
        if (q.bit_cnt == TCR_BIT_ACK) begin
          d.sda_low = 1'b0;
          unique case (q.i2_state)
            TCR_I2_IDLE: begin
            end
            TCR_I2_ADDR: begin
              if (link_shift_q[7:1] == {TCR_ADDR_PREFIX, q.addr_lo}) begin
                d.sda_low = 1'b1;
                d.rw      = link_shift_q[0];
              end else begin
                d.i2_state = TCR_I2_IDLE;
              end
            end
            TCR_I2_REG: begin
              d.ptr      = link_shift_q;
              d.byte_sel = 1'b0;
              d.sda_low  = 1'b1;
              d.i2_state = TCR_I2_WDATA;
            end
            TCR_I2_WDATA: begin
              d.sda_low = 1'b1;
              d.ptr     = q.ptr + 8'h01;
              unique case (q.ptr)
                TCR_REG_SETUP:     d.setup     = link_shift_q;
                TCR_REG_INT_EN:    d.int_en    = link_shift_q;
                TCR_REG_PIN_SETUP: d.pin_setup = link_shift_q;
                default: begin
                end
              endcase
            end
            TCR_I2_RDATA: begin
            end
            // Illegal code: drop the frame, wait for next start
            default: begin
              d.i2_state = TCR_I2_IDLE;
            end
          endcase
        end else if (q.bit_cnt == TCR_BIT_END) begin
          d.bit_cnt = 4'h0;
          d.sda_low = 1'b0;
          if ((q.i2_state == TCR_I2_ADDR && q.rw) ||
              (q.i2_state == TCR_I2_RDATA && q.mack)) begin
            d.i2_state = TCR_I2_RDATA;
            d.tx = reg_read(q.ptr, q.byte_sel, word_valid, word_data,
                            status, q.int_en, q.setup, q.pin_setup);
            d.sda_low = ~d.tx[7];
            d.tx      = {d.tx[6:0], 1'b0};
            if (q.ptr == TCR_REG_FIFO_WORD) begin
              pop        = q.byte_sel & word_valid;
              d.byte_sel = ~q.byte_sel;
            end else begin
              d.ptr = q.ptr + 8'h01;
            end
          end else if (q.i2_state == TCR_I2_ADDR) begin
            d.i2_state = TCR_I2_REG;
          end else if (q.i2_state == TCR_I2_RDATA) begin
            d.i2_state = TCR_I2_IDLE;
          end
        end else if (q.i2_state == TCR_I2_RDATA) begin
          d.sda_low = ~q.tx[7];
          d.tx      = {q.tx[6:0], 1'b0};
        end
      end
    end

    unique case (q.cv_state)
      TCR_CV_STANDBY: begin
        if (q.setup[TCR_CONV_START_BIT] || ext_trig) begin
          d.cv_state = TCR_CV_RUN;
          d.cv_cnt   = '0;
          d.setup[TCR_CONV_START_BIT] = 1'b1;
        end
      end
      TCR_CV_RUN: begin
        // Host writes cannot clear the start bit mid-conversion
        d.setup[TCR_CONV_START_BIT] = 1'b1;
        if (q.cv_cnt == CONV_LAST) begin
          // converter scales to 0.005 C units
          d.sample   = temp_reading;
          d.cv_state = TCR_CV_STORE;
        end else begin
          d.cv_cnt = q.cv_cnt + 1'b1;
        end
      end
      // A full buffer stalls here rather than drop the reading
      TCR_CV_STORE: begin
        if (push_ready) begin
          d.setup[TCR_CONV_START_BIT] = 1'b0;
          d.cv_state = TCR_CV_STANDBY;
        end else begin
          d.setup[TCR_CONV_START_BIT] = 1'b1;
        end
      end
      // Unused code: fall back to standby
      default: begin
        d.cv_state = TCR_CV_STANDBY;
      end
    endcase

    d.pin0_drive = (mode_zero == TCR_MODE_OUTPUT) ||
                   ((mode_zero == TCR_MODE_SPECIAL) &&
                    (|(q.int_en & status)));
    d.pin1_drive = (mode_one == TCR_MODE_OUTPUT);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      q           <= '0;
      q.scl_m     <= 1'b1;
      q.scl_s     <= 1'b1;
      q.scl_p     <= 1'b1;
      q.sda_m     <= 1'b1;
      q.sda_s     <= 1'b1;
      q.sda_p     <= 1'b1;
      // Trigger history starts at the pulled-down idle level,
      // so no false falling edge follows reset
      q.i2_state  <= TCR_I2_IDLE;
      q.cv_state  <= TCR_CV_STANDBY;
      q.setup     <= TCR_SETUP_RST;
      q.int_en    <= TCR_INT_EN_RST;
      q.pin_setup <= TCR_PIN_SETUP_RST;
    end else begin
      q <= d;
    end
  end

  tcr_fifo #(
    .WIDTH (TCR_READ_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (q.sample),
    .out_valid (word_valid),
    .out_ready (pop),
    .out_data  (word_data)
  );

  // Open-drain style: pins only ever pull low
  assign sda_o           = 1'b0;
  assign sda_oe          = q.sda_low;
  assign aux_pin_zero_o  = 1'b0;
  assign aux_pin_zero_oe = q.pin0_drive;
  assign aux_pin_one_o   = 1'b0;
  assign aux_pin_one_oe  = q.pin1_drive;
  assign conversion_busy = (q.cv_state != TCR_CV_STANDBY);

endmodule // tcr_readout

// >>> tcr_pkg.sv
// Purpose: Shared constants and types of the temperature conversion readout
// Assumes: ref_clk at 250 MHz, registers reached over the two-wire link
// Notes:   Offsets are byte pointers as seen by the link master
package tcr_pkg;

  // Register pointers
  localparam logic [7:0] TCR_REG_STATUS     = 8'h00;
  localparam logic [7:0] TCR_REG_INT_EN     = 8'h01;
  localparam logic [7:0] TCR_REG_FIFO_WORD  = 8'h08;
  localparam logic [7:0] TCR_REG_SETUP      = 8'h14;
  localparam logic [7:0] TCR_REG_PIN_SETUP  = 8'h20;

  // Reset values
  localparam logic [7:0] TCR_SETUP_RST      = 8'h00;
  localparam logic [7:0] TCR_INT_EN_RST     = 8'h00;
  localparam logic [7:0] TCR_PIN_SETUP_RST  = 8'h82;

  // Field positions
  localparam int TCR_CONV_START_BIT  = 0;
  localparam int TCR_PIN_ZERO_LSB    = 0;
  localparam int TCR_PIN_ONE_LSB     = 6;
  localparam int TCR_STAT_NONEMPTY   = 0;
  localparam int TCR_STAT_BUSY       = 1;

  // Pin modes
  localparam logic [1:0] TCR_MODE_HIZ_IN    = 2'h0;
  localparam logic [1:0] TCR_MODE_OUTPUT    = 2'h1;
  localparam logic [1:0] TCR_MODE_PULLDOWN  = 2'h2;
  localparam logic [1:0] TCR_MODE_SPECIAL   = 2'h3;

  // Fixed upper address bits of the link address
  localparam logic [4:0] TCR_ADDR_PREFIX    = 5'h14;

  // Bit counter marks within one link byte
  localparam logic [3:0] TCR_BIT_ACK        = 4'h8;
  localparam logic [3:0] TCR_BIT_END        = 4'h9;

  // Timing
  localparam int TCR_REF_CLK_MHZ   = 250;
  localparam int TCR_CONV_TIME_US  = 15000;
  localparam int TCR_CONV_CYCLES   = TCR_CONV_TIME_US * TCR_REF_CLK_MHZ;

  // Data path
  localparam int TCR_READ_WIDTH    = 16;
  localparam int TCR_FIFO_DEPTH    = 32;

  typedef enum logic [2:0] {
    TCR_I2_IDLE  = 3'h0,
    TCR_I2_ADDR  = 3'h1,
    TCR_I2_REG   = 3'h3,
    TCR_I2_WDATA = 3'h2,
    TCR_I2_RDATA = 3'h6
  } tcr_link_state_type;

  typedef enum logic [1:0] {
    TCR_CV_STANDBY = 2'h0,
    TCR_CV_RUN     = 2'h1,
    TCR_CV_STORE   = 2'h3
  } tcr_conv_state_type;

endpackage

// >>> tcr_fifo.sv
// Purpose: Reading buffer between conversion and link readout
// Assumes: One clock; write and read may happen in the same cycle
// Notes:   Depth must be a power of two
module tcr_fifo
  import tcr_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } tcr_fifo_state_type;

  tcr_fifo_state_type q;
  tcr_fifo_state_type d;
  logic [WIDTH-1:0]   mem [DEPTH];
  logic               full;
  logic               empty;

  assign full      = (q.wr_ptr[AW] != q.rd_ptr[AW]) &&
                     (q.wr_ptr[AW-1:0] == q.rd_ptr[AW-1:0]);
  assign empty     = (q.wr_ptr == q.rd_ptr);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem[q.rd_ptr[AW-1:0]];

  always_comb begin
    d = q;
    if (in_valid && !full) begin
      d.wr_ptr = q.wr_ptr + 1'b1;
    end
    if (out_ready && !empty) begin
      d.rd_ptr = q.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Storage needs no reset; only the pointers decide what is valid
  always_ff @(posedge ref_clk) begin
    if (in_valid && !full) begin
      mem[q.wr_ptr[AW-1:0]] <= in_data;
    end
  end

endmodule // tcr_fifo

// >>> tcr_readout_props.sv
// Purpose: Port-level timing checks of the readout block
// Assumes: Link master parks SCL high between frames
// Notes:   Bound into every tcr_readout instance
module tcr_readout_props
  import tcr_pkg::*;
#(
  parameter int CONV_CYCLES = TCR_CONV_CYCLES,
  parameter int FIFO_DEPTH  = TCR_FIFO_DEPTH
) (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        scl_clk,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        aux_pin_zero_i,
  input wire logic        aux_pin_zero_o,
  input wire logic        aux_pin_zero_oe,
  input wire logic        aux_pin_one_i,
  input wire logic        aux_pin_one_o,
  input wire logic        aux_pin_one_oe,
  input wire logic [15:0] temp_reading,
  input wire logic        conversion_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned busy_n, scl_hi, p1_lo;
  logic        link_seen;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      busy_n    <= 0;
      scl_hi    <= 0;
      p1_lo     <= 0;
      link_seen <= 1'b0;
    end else begin
      busy_n    <= conversion_busy ? busy_n + 1 : 0;
      scl_hi    <= scl_clk ? scl_hi + 1 : 0;
      p1_lo     <= aux_pin_one_i ? 0 : p1_lo + 1;
      link_seen <= link_seen | sda_oe;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_ack_soon;
    ##[0:4] sda_oe;
  endsequence
  sequence s_pin_fell;
    p1_lo inside {[1:11]};
  endsequence

  a_reset_quiet: assert property (
    $rose(reset_n) |-> !conversion_busy && !sda_oe && !aux_pin_zero_oe
      && !aux_pin_one_oe) else $error("outputs active after reset");
  a_busy_min_len: assert property (
    $fell(conversion_busy) |-> busy_n >= CONV_CYCLES)
    else $error("conversion ended early");
  a_busy_has_cause: assert property (
    $rose(conversion_busy) |-> s_pin_fell or s_ack_soon)
    else $error("conversion started without request");
  a_idle_no_drive: assert property (
    scl_hi > 8 |-> !sda_oe) else $error("data held while clock parked");
  a_drive_after_fall: assert property (
    $rose(sda_oe) |-> scl_hi < 3) else $error("data pulled late in bit");
  a_ack_bounded: assert property (
    $rose(sda_oe) |-> ##[1:120] !sda_oe) else $error("data held too long");
  a_open_drain: assert property (
    !sda_o && !aux_pin_zero_o && !aux_pin_one_o)
    else $error("open drain output driven high");
  a_pin_oe_cause: assert property (
    (aux_pin_zero_oe || aux_pin_one_oe) |-> link_seen)
    else $error("pin driven before any setup write");
endmodule // tcr_readout_props

bind tcr_readout tcr_readout_props #(
  .CONV_CYCLES(CONV_CYCLES),
  .FIFO_DEPTH (FIFO_DEPTH)
) tcr_readout_props_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .scl_clk(scl_clk), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .aux_pin_zero_i(aux_pin_zero_i),
  .aux_pin_zero_o(aux_pin_zero_o), .aux_pin_zero_oe(aux_pin_zero_oe),
  .aux_pin_one_i(aux_pin_one_i), .aux_pin_one_o(aux_pin_one_o),
  .aux_pin_one_oe(aux_pin_one_oe), .temp_reading(temp_reading),
  .conversion_busy(conversion_busy));

// >>> tcr_host.sv
// Purpose: Two-wire link master standing in for the host
// Assumes: Bench builds the SDA wire with a pull-up
// Notes:   SCL parks high between frames; 30 ns bit period
module tcr_host
  import tcr_pkg::*;
(
  output logic       scl_clk,
  output logic       sda_pull,
  input  wire  logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] dev_addr = {TCR_ADDR_PREFIX, 3'h0};

  initial begin
    scl_clk  = 1'b1;
    sda_pull = 1'b0;
  end

  // Data moves 2 ns after the fall, so it never looks like framing
  task automatic bit_io(input logic tx, output logic rx);
    #2 sda_pull = !tx;
    #13 scl_clk = 1'b1;
    #14 rx = sda;
    #1 scl_clk = 1'b0;
  endtask

  // Start when first is 0, stop when 1
  task automatic edge_sda(input logic first);
    #2 sda_pull = first;
    #20 scl_clk = 1'b1;
    #40 sda_pull = !first;
    #40 scl_clk = first;
  endtask

  task automatic xfer(input logic [7:0] b, input logic ak,
                      output logic [7:0] r, output logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(ak, a);
    ok = !a;
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d,
                    output logic ok);
    logic [7:0] r;
    logic       a0, a1, a2;
    edge_sda(1'b0);
    xfer(dev_addr, 1'b1, r, a0);
    xfer(p, 1'b1, r, a1);
    xfer(d, 1'b1, r, a2);
    edge_sda(1'b1);
    ok = a0 & a1 & a2;
  endtask

  task automatic rd(input logic [7:0] p, output logic [15:0] w,
                    output logic ok);
    logic [7:0] r;
    logic       a0, a1, a2, x;
    edge_sda(1'b0);
    xfer(dev_addr, 1'b1, r, a0);
    xfer(p, 1'b1, r, a1);
    edge_sda(1'b0);
    xfer(dev_addr | 8'h01, 1'b1, r, a2);
    xfer(8'hFF, 1'b0, w[15:8], x);
    xfer(8'hFF, 1'b1, w[7:0], x);
    edge_sda(1'b1);
    ok = a0 & a1 & a2;
  endtask
endmodule // tcr_host

// >>> temp_conversion_readout_test.sv
// Purpose: Self-checking bench of the readout block
// Assumes: Conversion shortened to 400 cycles, buffer of 4 words
// Notes:   Host model drives the link; bench drives pins and reading
module temp_conversion_readout_test
  import tcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CONV = 400;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        scl_clk, sda_pull, sda_o, sda_oe, busy;
  logic        p0_o, p0_oe, p1_o, p1_oe;
  logic        p0_drv = 1'b0;
  logic        p1_drv = 1'b0;
  logic [15:0] reading = 16'h0000;
  int          n_fail = 0;
  int          n_checks = 0;
  wire         sda = !(sda_pull | sda_oe);
  wire         p0 = p0_oe ? 1'b0 : p0_drv;
  wire         p1 = p1_oe ? 1'b0 : p1_drv;

  always #2 ref_clk = !ref_clk;

  tcr_host tcr_host_i (.scl_clk(scl_clk), .sda_pull(sda_pull), .sda(sda));
  tcr_readout #(.CONV_CYCLES(CONV), .FIFO_DEPTH(4)) tcr_readout_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .scl_clk(scl_clk), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .aux_pin_zero_i(p0),
    .aux_pin_zero_o(p0_o), .aux_pin_zero_oe(p0_oe), .aux_pin_one_i(p1),
    .aux_pin_one_o(p1_o), .aux_pin_one_oe(p1_oe), .temp_reading(reading),
    .conversion_busy(busy));

  function automatic logic [7:0] dev_of(input logic a1, input logic a0);
    return {TCR_ADDR_PREFIX, a1, a0, 1'b0};
  endfunction
  function automatic logic [15:0] code_of(input int milli_c);
    return 16'(milli_c / 5);
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (busy !== lvl && k < 2000) begin
      tick();
      k++;
    end
    chk("busy level", 16'(lvl), 16'(busy));
  endtask
  task automatic wreg(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    tcr_host_i.wr(p, d, ok);
    chk("write ack", 16'h0001, 16'(ok));
  endtask
  task automatic rword(input logic [7:0] p, input logic [15:0] e);
    logic [15:0] w;
    logic        ok;
    tcr_host_i.rd(p, w, ok);
    chk("read ack", 16'h0001, 16'(ok));
    chk("read data", e, w);
  endtask

  // Whole run is about 47 us, some 37 us of it link traffic
  initial begin
    #300000;
    n_fail++;
    conclude();
  end

  initial begin
    logic [15:0] q[$];
    logic [15:0] v, w;
    logic        ok;
    void'($urandom(89492));
    repeat (6) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (4) tick();
    rword(TCR_REG_SETUP, {TCR_SETUP_RST, 8'h00});
    rword(TCR_REG_PIN_SETUP, {TCR_PIN_SETUP_RST, 8'h00});
    chk("idle busy", 16'h0000, 16'(busy));
    tcr_host_i.dev_addr = dev_of(1'b0, 1'b1);
    tcr_host_i.rd(TCR_REG_SETUP, w, ok);
    chk("foreign address ack", 16'h0000, 16'(ok));
    tick();
    p0_drv = 1'b1;
    rword(TCR_REG_INT_EN, {TCR_INT_EN_RST, 8'h00});
    tick();
    p0_drv = 1'b0;
    tcr_host_i.dev_addr = dev_of(1'b0, 1'b0);
    for (int i = 0; i < 5; i++) begin
      v = i == 0 ? 16'h8000 : i == 1 ? code_of(-40000)
        : i == 2 ? code_of(37000) : 16'($urandom());
      tick();
      reading = v;
      q.push_back(v);
      wreg(TCR_REG_SETUP, 8'h01);
      if (i == 1) wreg(TCR_REG_SETUP, 8'h01);
      chk("busy", 16'h0001, 16'(busy));
      if (i < 4) begin
        wait_busy(1'b0);
        rword(TCR_REG_SETUP, 16'h0000);
      end
    end
    repeat (2 * CONV) tick();
    chk("full busy", 16'h0001, 16'(busy));
    foreach (q[k]) rword(TCR_REG_FIFO_WORD, q[k]);
    rword(TCR_REG_FIFO_WORD, 16'h0000);
    chk("drained busy", 16'h0000, 16'(busy));
    wreg(TCR_REG_INT_EN, 8'h01);
    wreg(TCR_REG_PIN_SETUP, 8'hC3);
    tick();
    p1_drv = 1'b1;
    v = 16'($urandom());
    reading = v;
    repeat (8) tick();
    p1_drv = 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    repeat (4) tick();
    chk("alert pin", 16'h0001, 16'(p0_oe));
    rword(TCR_REG_FIFO_WORD, v);
    repeat (8) tick();
    chk("alert pin", 16'h0000, 16'(p0_oe));
    reset_n = 1'b0;
    repeat (6) tick();
    reset_n = 1'b1;
    repeat (4) tick();
    rword(TCR_REG_PIN_SETUP, {TCR_PIN_SETUP_RST, 8'h00});
    wreg(TCR_REG_PIN_SETUP, 8'h41);
    repeat (4) tick();
    chk("pin one drive", 16'h0001, 16'(p1_oe));
    chk("pin zero drive", 16'h0001, 16'(p0_oe));
    rword(TCR_REG_PIN_SETUP, {8'h41, 8'h00});
    conclude();
  end
endmodule // temp_conversion_readout_test
